// ---- logic/twrp_pkg.sv ----
`default_nettype none
package twrp_pkg;
   // ***********************************************
   // clock and link timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_KHZ = 100000;
   localparam int SCLK_MAX_KHZ = 19200;
   localparam int HALF_MIN = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   // one spare cycle per half period leaves room for the input synchroniser
   localparam int HALF = HALF_MIN + 1;
   localparam int SAMPLE_AT = 2;
   localparam int HRST_NS = 100;
   localparam int HRST_CYC = (HRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EN_LOW_CYC = 2 * HALF;
   localparam int SETTLE_US = 500;
   localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_PERIOD_NS;
   localparam int TUNE_US = 50;
   localparam int TUNE_CYC = TUNE_US * 1000 / CLK_PERIOD_NS;
   // ***********************************************
   // frame layout, counted in rising serial clock edges
   // ***********************************************
   localparam logic START_BIT = 1'b0;
   localparam logic [4:0] R_FIRST = 5'd1;
   localparam logic [4:0] R_RD_REL = 5'd10;
   localparam logic [4:0] R_RD_FIRST = 5'd13;
   localparam logic [4:0] R_RD_LAST = 5'd28;
   localparam logic [4:0] R_RD_DONE = 5'd29;
   localparam logic [4:0] R_WR_END = 5'd26;
   localparam logic [4:0] R_WR_DONE = 5'd27;
   localparam logic [6:0] BANK_BASE = 7'h08;
   // ***********************************************
   // software registers
   // ***********************************************
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_PINS = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam int CMD_RD = 7;
   localparam int PIN_EN = 0;
   localparam int PIN_BANK = 1;
   localparam int PIN_HRST = 2;
   localparam int PIN_CYCLE = 3;
   localparam int PIN_SETTLE = 4;
   localparam logic BANK_RST = 1'b1;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } twrp_req_type;
   typedef enum {S_IDLE, S_FRAME, S_RESET, S_ENLOW, S_SETTLE} twrp_state_type;
endpackage
`default_nettype wire

// ---- logic/twrp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module twrp_sync
   import twrp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
      end else begin
         ff1 <= pin;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // a change counts only once two settled stages agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         level <= 1'b0;
      end else if (ff2 == ff3) begin
         level <= ff3;
      end
   end

   a_sync_agree: assert property (@(posedge clk) disable iff (!rst_b)
      $changed(level) |-> $past(ff2) == $past(ff3))
      else $error("level moved without agreement");
endmodule
`default_nettype wire

// ---- logic/twrp_host.sv ----
// Notes on behaviour
// RULE_01 - between frames frame enable high, data line released by both ends
// RULE_02 - start serial clock, pull frame enable low on first falling edge
// RULE_03 - second rising edge initialises input stage, third carries write/read bit
// RULE_04 - write frame: start, 0, 7-bit address msb first, 16-bit payload
// RULE_05 - controller drives data whole write frame, device samples rising edges
// RULE_06 - device commits write on final rising edge after frame enable rises
// RULE_07 - serial clock never faster than 19.2 MHz
// RULE_08 - one extra rising edge before frame enable goes low
// RULE_09 - read frame: start, 1, address, 1.5 bit gap, 16 data bits
// RULE_10 - device updates data on rising edge, controller samples on falling
// RULE_11 - controller releases line before device drives, three edges after address
// RULE_12 - after read data device releases line, controller raises frame enable
// RULE_13 - enable pin low keeps analog off; keepalive holds oscillator on
// RULE_14 - enable pin rising starts band selection; needed after each reprogramming
// RULE_15 - hard reset low at least 100 ns restores defaults
// RULE_16 - device resets itself at power on; hard reset may be tied high
// RULE_17 - bank pin picks register bank only when dual bank select set
// RULE_18 - after switching banks, cycle the enable pin to relock
// RULE_19 - keepalive bit reads 0 after reset
// RULE_20 - set keepalive about 500 us before raising enable pin
// RULE_21 - coarse tuning takes about 50 us at 26 MHz reference
// RULE_22 - four writes per path set frequency, three for small shifts
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module twrp_host
   import twrp_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int TUNE_CYCLES = TUNE_CYC
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire twrp_req_type sw_req,
   output logic [31:0] sw_rdata,
   output logic sclk,
   output logic frame_enable_n,
   output logic serial_data_out,
   output logic serial_data_oe_b,
   input wire logic serial_data_in,
   output logic analog_enable_pin,
   output logic bank_select_pin,
   output logic hard_reset_n
);
   // ***********************************************
   // state
   // ***********************************************
   twrp_state_type state;
   logic [2:0] phase;
   logic [4:0] rise;
   logic [24:0] shifter;
   logic is_rd;
   logic [15:0] wdata;
   logic [15:0] rd_shift;
   logic [15:0] rd_data;
   logic [15:0] wcnt;
   logic [15:0] tcnt;
   logic [3:0] fcnt;
   logic en_d;
   logic sd_level;
   logic tick;
   logic fall_evt;
   logic sample_evt;
   logic frame_done;
   logic wait_done;
   logic cmd_wr;
   logic pins_wr;
   logic settle_req;
   logic en_rise;
   logic bank_wr;
   logic [31:0] next_rdata;

   function automatic logic hit(twrp_req_type r, logic [7:0] a);
      return r.addr == a;
   endfunction

   function automatic logic [15:0] wait_last(twrp_state_type s);
      if (s == S_RESET) begin
         return 16'(HRST_CYC - 1);
      end else if (s == S_ENLOW) begin
         return 16'(EN_LOW_CYC - 1);
      end
      return 16'(SETTLE_CYCLES - 1);
   endfunction

   twrp_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin(serial_data_in),
      .level(sd_level)
   );

   // ***********************************************
   // decode and events
   // ***********************************************
   assign cmd_wr = state == S_IDLE && sw_req.wr && hit(sw_req, REG_CMD);
   assign pins_wr = state == S_IDLE && sw_req.wr && hit(sw_req, REG_PINS);
   assign settle_req = sw_req.wdata[PIN_SETTLE] && sw_req.wdata[PIN_EN]
      && !analog_enable_pin;
   assign tick = state == S_FRAME && phase == 3'(HALF - 1);
   assign fall_evt = tick && sclk;
   assign sample_evt = state == S_FRAME && is_rd && !sclk
      && phase == 3'(SAMPLE_AT) && rise >= R_RD_FIRST && rise <= R_RD_LAST; // RULE_10
   assign frame_done = fall_evt && rise == (is_rd ? R_RD_DONE : R_WR_DONE);
   assign wait_done = wcnt == wait_last(state);
   assign en_rise = analog_enable_pin && !en_d;
   assign bank_wr = !sw_req.wdata[CMD_RD] && sw_req.wdata[6:0] >= BANK_BASE;

   // ***********************************************
   // sequencer
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (cmd_wr) begin
                  state <= S_FRAME;
               end else if (pins_wr && sw_req.wdata[PIN_HRST]) begin
                  state <= S_RESET;
               end else if (pins_wr && sw_req.wdata[PIN_CYCLE]) begin
                  state <= S_ENLOW;
               end else if (pins_wr && settle_req) begin
                  state <= S_SETTLE;
               end
            end
            S_FRAME: begin
               if (frame_done) begin
                  state <= S_IDLE;
               end
            end
            S_RESET, S_ENLOW, S_SETTLE: begin
               if (wait_done) begin
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || state == S_IDLE || state == S_FRAME || wait_done) begin
         wcnt <= 16'h0000;
      end else begin
         wcnt <= wcnt + 16'h0001;
      end
   end

   // ***********************************************
   // serial clock, divided from clk
   // ***********************************************
   // clock stays low outside frames, so the device sees no stray edges
   always_ff @(posedge clk) begin
      if (!rst_b || state != S_FRAME || tick) begin
         phase <= 3'h0;
      end else begin
         phase <= phase + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || state != S_FRAME) begin
         sclk <= 1'b0;
      end else if (tick) begin
         sclk <= !sclk; // RULE_07
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || state != S_FRAME) begin
         rise <= 5'h00;
      end else if (tick && !sclk) begin
         rise <= rise + 5'h01;
      end
   end

   // ***********************************************
   // frame data
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wdata <= 16'h0000;
      end else if (sw_req.wr && hit(sw_req, REG_WDATA)) begin
         wdata <= sw_req.wdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shifter <= 25'h0000000;
         is_rd <= 1'b0;
      end else if (cmd_wr) begin
         shifter <= {START_BIT, sw_req.wdata[CMD_RD], sw_req.wdata[6:0], wdata}; // RULE_04
         is_rd <= sw_req.wdata[CMD_RD]; // RULE_09
      end else if (fall_evt && rise > R_FIRST) begin
         shifter <= {shifter[23:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_enable_n <= 1'b1; // RULE_01
         serial_data_oe_b <= 1'b1;
         serial_data_out <= 1'b0;
      end else if (fall_evt) begin
         if (rise == R_FIRST) begin
            // the rising edge before this one is the extra free edge
            frame_enable_n <= 1'b0; // RULE_02 RULE_08
            serial_data_oe_b <= 1'b0;
            serial_data_out <= shifter[24]; // RULE_03
         end else if (rise == (is_rd ? R_RD_REL : R_WR_END)) begin
            serial_data_oe_b <= 1'b1; // RULE_11 RULE_01
         end else if (!serial_data_oe_b) begin
            serial_data_out <= shifter[23]; // RULE_05
         end
         if (rise == (is_rd ? R_RD_LAST : R_WR_END)) begin
            frame_enable_n <= 1'b1; // RULE_12
         end
      end
   end

   // sampling sits SAMPLE_AT cycles past the falling edge to absorb sync delay
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_shift <= 16'h0000;
      end else if (sample_evt) begin
         rd_shift <= {rd_shift[14:0], sd_level}; // RULE_10
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data <= 16'h0000;
      end else if (frame_done && is_rd) begin
         rd_data <= rd_shift;
      end
   end

   // ***********************************************
   // hardware control pins
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hard_reset_n <= 1'b1;
      end else if (pins_wr && sw_req.wdata[PIN_HRST]) begin
         hard_reset_n <= 1'b0; // RULE_15
      end else if (state == S_RESET && wait_done) begin
         hard_reset_n <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bank_select_pin <= BANK_RST;
      end else if (pins_wr) begin
         bank_select_pin <= sw_req.wdata[PIN_BANK];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         analog_enable_pin <= 1'b0;
      end else if (pins_wr) begin
         if (sw_req.wdata[PIN_HRST]) begin
            analog_enable_pin <= analog_enable_pin;
         end else if (sw_req.wdata[PIN_CYCLE]) begin
            analog_enable_pin <= 1'b0; // RULE_14 RULE_18
         end else if (!settle_req) begin
            analog_enable_pin <= sw_req.wdata[PIN_EN];
         end
      end else if ((state == S_ENLOW || state == S_SETTLE) && wait_done) begin
         analog_enable_pin <= 1'b1; // RULE_20
      end
   end

   // ***********************************************
   // tuning wait and reprogramming count
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         en_d <= 1'b0;
      end else begin
         en_d <= analog_enable_pin;
      end
   end

   // only an estimate: true duration scales with the reference frequency
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tcnt <= 16'h0000;
      end else if (en_rise) begin
         tcnt <= 16'(TUNE_CYCLES); // RULE_14
      end else if (tcnt != 16'h0000) begin
         tcnt <= tcnt - 16'h0001;
      end
   end

   // bank writes since the last enable rise; a write in the same cycle still counts
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fcnt <= 4'h0;
      end else if (en_rise) begin
         fcnt <= {3'h0, cmd_wr && bank_wr};
      end else if (cmd_wr && bank_wr && fcnt != 4'hf) begin
         fcnt <= fcnt + 4'h1; // RULE_22
      end
   end

   // ***********************************************
   // software read port
   // ***********************************************
   always_comb begin
      next_rdata = 32'h00000000;
      if (sw_req.rd) begin
         if (hit(sw_req, REG_WDATA)) begin
            next_rdata = {16'h0000, wdata};
         end else if (hit(sw_req, REG_PINS)) begin
            next_rdata = {30'h00000000, bank_select_pin, analog_enable_pin};
         end else if (hit(sw_req, REG_STAT)) begin
            next_rdata = {24'h000000, fcnt, 1'b0, tcnt != 16'h0000,
               state != S_IDLE && state != S_FRAME, state != S_IDLE};
         end else if (hit(sw_req, REG_RDATA)) begin
            next_rdata = {16'h0000, rd_data};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sw_rdata <= 32'h00000000;
      end else begin
         sw_rdata <= next_rdata;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_idle_lines: assert property ( // RULE_01
      state == S_IDLE |-> frame_enable_n && serial_data_oe_b)
      else $error("lines not idle between frames");
   a_enable_fall_edge: assert property ( // RULE_02
      $fell(frame_enable_n) |-> $fell(sclk) && rise == R_FIRST)
      else $error("frame enable fell off the first falling edge");
   a_sclk_high_time: assert property ( // RULE_07
      $rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase wrong");
   a_wr_frame_len: assert property ( // RULE_04
      $fell(frame_enable_n) && !is_rd |-> ##199 !frame_enable_n ##1 frame_enable_n)
      else $error("write frame length wrong");
   a_rd_frame_len: assert property ( // RULE_09
      $fell(frame_enable_n) && is_rd |-> ##215 !frame_enable_n ##1 frame_enable_n)
      else $error("read frame length wrong");
   a_wr_drive: assert property ( // RULE_05
      state == S_FRAME && !is_rd && !frame_enable_n |-> !serial_data_oe_b)
      else $error("line released during write");
   a_rd_release: assert property ( // RULE_11
      state == S_FRAME && is_rd && rise > R_RD_REL |-> serial_data_oe_b)
      else $error("line driven in read data phase");
   a_latch_edge: assert property ( // RULE_06
      $rose(frame_enable_n) && !is_rd |-> ##4 $rose(sclk))
      else $error("no final rising edge after write");
   a_hrst_len: assert property ( // RULE_15
      $fell(hard_reset_n) |-> ##9 !hard_reset_n ##1 hard_reset_n)
      else $error("hard reset pulse length wrong");
   a_en_cycle: assert property ( // RULE_18
      $fell(analog_enable_pin) && state == S_ENLOW |-> ##8 $rose(analog_enable_pin))
      else $error("enable cycle not completed");
   a_tune_wait: assert property ( // RULE_14
      $rose(analog_enable_pin) |=> tcnt == 16'(TUNE_CYCLES))
      else $error("tuning wait not started");

   c_write_done: cover property (frame_done && !is_rd);
   c_read_done: cover property (frame_done && is_rd);
   c_hard_reset: cover property ($rose(hard_reset_n));
   c_settle_rise: cover property (state == S_SETTLE && wait_done);
endmodule
`default_nettype wire

// ---- bench/twrp_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module twrp_dev_model (
   input wire logic clk,
   input wire logic sclk,
   input wire logic frame_enable_n,
   input wire logic serial_data_out,
   input wire logic serial_data_oe_b,
   input wire logic analog_enable_pin,
   input wire logic bank_select_pin,
   input wire logic hard_reset_n,
   output logic serial_data_in,
   output logic osc_on,
   output logic use_first_bank,
   output int band_starts,
   output int faults
);
   // ***********************************
   // serial port of the device
   // ***********************************
   logic [15:0] regs [0:127];
   logic [24:0] sh = '0;
   logic [6:0] ra = '0;
   int cnt = 0;
   logic drv = 1'b0, dbit = 1'b0, flt = 1'b0, pre_rise = 1'b0, rd = 1'b0;
   logic en_q = 1'b1, sck_q = 1'b0;
   time rst_t = 0;
   initial band_starts = 0;
   initial faults = 0;
   initial foreach (regs[i]) regs[i] <= 16'h0;
   // no pull on the line: a released line toggles so stale data never matches
   assign serial_data_in = drv ? dbit : (!serial_data_oe_b ? serial_data_out : flt);
   assign osc_on = analog_enable_pin | regs[2][0];
   assign use_first_bank = regs[0][1] & !bank_select_pin;
   always @(posedge analog_enable_pin) band_starts++;
   always @(negedge clk) begin
      flt <= ~flt;
      en_q <= frame_enable_n;
      sck_q <= sclk;
      if (en_q && !frame_enable_n && !(sck_q && !sclk)) faults++;
   end
   always @(posedge sclk) begin
      if (frame_enable_n) begin
         if (cnt == 25 && !rd) regs[sh[22:16]] <= sh[15:0];
         pre_rise <= (cnt == 0);
         drv <= 1'b0;
         rd <= 1'b0;
         cnt <= 0;
      end else begin
         if (cnt == 0 && !pre_rise) faults++;
         if (serial_data_oe_b && !drv && (cnt < 9 || !rd)) faults++;
         if (!serial_data_oe_b && rd && cnt > 10) faults++;
         if (cnt == 8) {rd, ra} <= {sh[6:0], serial_data_in};
         if (rd && cnt > 10 && cnt < 27) begin
            drv <= 1'b1;
            dbit <= regs[ra][26 - cnt];
         end
         sh <= {sh[23:0], serial_data_in};
         cnt <= cnt + 1;
      end
   end
   always @(negedge hard_reset_n) rst_t = $time;
   always @(posedge hard_reset_n) begin
      if (rst_t > 0 && $time - rst_t < 100) faults++;
      foreach (regs[i]) regs[i] <= 16'h0;
   end
endmodule
`default_nettype wire

// ---- bench/twrp_host_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module twrp_host_tb_top;
   import twrp_pkg::*;
   localparam int SETTLE = 20;
   localparam int TUNE = 16;
   logic clk = 1'b0, rst_b = 1'b0;
   twrp_req_type req = '0;
   logic [31:0] rdata, s;
   logic sclk, fen_n, sdo, oe_b, line_in, aen, bank, hrst_n, osc_on, first_bank;
   logic sc_q = 1'b0, hr_q = 1'b1;
   int band_starts, faults, bad_count = 0, n_checks = 0, b0, n;
   int per = 0, min_per = 999, hlow = 0, min_hlow = 999;
   logic [6:0] t_a [3] = '{7'h7f, 7'h00, 7'h02};
   logic [15:0] t_d [3] = '{16'h8001, 16'h7ffe, 16'h0001};
   always #5 clk = ~clk;
   twrp_host #(.SETTLE_CYCLES(SETTLE), .TUNE_CYCLES(TUNE)) dut (.clk(clk), .rst_b(rst_b),
      .sw_req(req), .sw_rdata(rdata), .sclk(sclk), .frame_enable_n(fen_n),
      .serial_data_out(sdo), .serial_data_oe_b(oe_b), .serial_data_in(line_in),
      .analog_enable_pin(aen), .bank_select_pin(bank), .hard_reset_n(hrst_n));
   twrp_dev_model model (.clk(clk), .sclk(sclk), .frame_enable_n(fen_n),
      .serial_data_out(sdo), .serial_data_oe_b(oe_b), .analog_enable_pin(aen),
      .bank_select_pin(bank), .hard_reset_n(hrst_n), .serial_data_in(line_in),
      .osc_on(osc_on), .use_first_bank(first_bank), .band_starts(band_starts),
      .faults(faults));
   // ***********************************
   // monitors: sampled mid-cycle to stay clear of the launch edge
   // ***********************************
   always @(negedge clk) begin
      sc_q <= sclk;
      hr_q <= hrst_n;
      per <= (sclk && !sc_q) ? 1 : per + 1;
      if (sclk && !sc_q && per < min_per) min_per <= per;
      hlow <= hrst_n ? 0 : hlow + 1;
      if (hrst_n && !hr_q && hlow < min_hlow) min_hlow <= hlow;
   end
   // ***********************************
   // helpers
   // ***********************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      req.rd <= 1'b0;
      // read data stands in the cycle after the strobe: take it at that cycle's closing edge
      @(posedge clk);
      d = rdata;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 400; i++) begin
         bus_rd(REG_STAT, s);
         if (s[1:0] === 2'b00) return;
      end
      check("idle wait", 32'h0, s);
      give_verdict();
   endtask
   // a write frame loads the payload register first
   task automatic frame(input logic r, input logic [6:0] a, input logic [15:0] d);
      if (!r) bus_wr(REG_WDATA, {16'h0, d});
      bus_wr(REG_CMD, {24'h0, r, a});
      wait_idle();
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic sc_reset();
      check("idle pins", 32'h1b, {26'h0, sclk, fen_n, oe_b, aen, bank, hrst_n});
      check("oscillator", 32'h0, {31'h0, osc_on});
      bus_rd(8'h20, s);
      check("unmapped read", 32'h0, s);
   endtask
   task automatic sc_frames();
      foreach (t_a[i]) begin
         frame(1'b0, t_a[i], t_d[i]);
         check("written reg", {16'h0, t_d[i]}, {16'h0, model.regs[t_a[i]]});
      end
      foreach (t_a[i]) begin
         frame(1'b1, t_a[i], 16'h0);
         bus_rd(REG_RDATA, s);
         check("read data", {16'h0, t_d[i]}, {16'h0, s[15:0]});
         check("end of read", 32'h3, {30'h0, fen_n, oe_b});
      end
      check("sclk period ok", 32'h1, {31'h0, min_per >= 6});
      check("link faults", 32'h0, faults);
      check("keepalive", 32'h1, {31'h0, osc_on});
   endtask
   task automatic sc_pins();
      b0 = band_starts;
      bus_wr(REG_PINS, 32'h0);
      // pins launch on the edge that takes the write, so look one edge later
      @(posedge clk);
      check("first bank", 32'h1, {30'h0, bank, first_bank});
      bus_wr(REG_PINS, 32'h11);
      for (n = 0; n < 200 && aen !== 1'b1; n++) @(posedge clk);
      check("settle wait", 32'h1, {31'h0, n >= SETTLE && n <= SETTLE + 2});
      if (aen !== 1'b1) give_verdict();
      check("band start", b0 + 1, band_starts);
      bus_rd(REG_STAT, s);
      check("tuning", 32'h1, {31'h0, s[2]});
      repeat (TUNE + 2) @(posedge clk);
      bus_rd(REG_STAT, s);
      check("tuning over", 32'h0, {31'h0, s[2]});
      for (int i = 0; i < 4; i++) frame(1'b0, 7'h10 + 7'(i), 16'h1111 * 16'(i));
      bus_rd(REG_STAT, s);
      check("bank writes", 32'h4, {28'h0, s[7:4]});
      // bank changes to the second one, so the enable pin must be cycled
      bus_wr(REG_PINS, 32'h0b);
      wait_idle();
      check("relock", b0 + 2, band_starts);
      check("second bank", 32'h6, {29'h0, aen, bank, first_bank});
      bus_rd(REG_STAT, s);
      check("count cleared", 32'h0, {28'h0, s[7:4]});
      bus_wr(REG_PINS, 32'h4);
      wait_idle();
      check("reset pulse", 32'h1, {31'h0, min_hlow >= HRST_CYC});
      check("regs cleared", 32'h0, {16'h0, model.regs[7'h7f]});
      check("keepalive cleared", 32'h0, {16'h0, model.regs[2]});
      check("pin faults", 32'h0, faults);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      sc_reset();
      sc_frames();
      sc_pins();
      give_verdict();
   end
endmodule
`default_nettype wire
